// >>> core/bmce_regs.vh
// register indices, field positions, opcodes and machine-cycle lengths
`ifndef BMCE_REGS_VH
`define BMCE_REGS_VH
// register port indices
`define BMCE_IDX_ACC 4'h0
`define BMCE_IDX_FLAGS 4'h1
`define BMCE_IDX_BYTE_CTR 4'h2
`define BMCE_IDX_TARGET 4'h3
`define BMCE_IDX_SOURCE 4'h4
`define BMCE_IDX_STACK_TOP 4'h5
`define BMCE_IDX_FIRST_BASE 4'h6
`define BMCE_IDX_SECOND_BASE 4'h7
`define BMCE_IDX_PC 4'h8
`define BMCE_IDX_CMD 4'h9
`define BMCE_IDX_STATUS 4'hA
// flag bit positions
`define BMCE_FLAG_S 7
`define BMCE_FLAG_Z 6
`define BMCE_FLAG_H 4
`define BMCE_FLAG_PV 2
`define BMCE_FLAG_N 1
`define BMCE_FLAG_C 0
// status bit positions
`define BMCE_ST_BUSY 0
`define BMCE_ST_BAD_OP 1
`define BMCE_ST_INT_TAKEN 2
// opcodes
`define BMCE_PFX_FIRST 8'hDD
`define BMCE_PFX_SECOND 8'hFD
`define BMCE_PFX_BLOCK 8'hED
`define BMCE_OP_SWAP_STACK 8'hE3
`define BMCE_OP_COPY_UP 8'hA0
`define BMCE_OP_COPY_REP_UP 8'hB0
`define BMCE_OP_COPY_DOWN 8'hA8
`define BMCE_OP_COPY_REP_DOWN 8'hB8
`define BMCE_OP_CMP_UP 8'hA1
// machine-cycle lengths in clock states
`define BMCE_T3 3'd3
`define BMCE_T4 3'd4
`define BMCE_T5 3'd5
// reset values
`define BMCE_RST_WORD 16'h0000
`define BMCE_RST_BYTE 8'h00
`endif

// >>> core/bmce_buf2.v
// two-entry valid/ready buffer for bytes returned by memory
`timescale 1ns/1ns
`default_nettype none
module bmce_buf2 #(
   parameter W = 8
) (
   input wire clk,
   input wire arst_n,
   input wire in_valid,
   output reg in_ready,
   input wire [W-1:0] in_data,
   output reg out_valid,
   input wire out_ready,
   output reg [W-1:0] out_data
);
   reg [W-1:0] spare_r;
   reg spare_vld_r;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_ready <= 1'b1;
         out_valid <= 1'b0;
         out_data <= {W{1'b0}};
         spare_r <= {W{1'b0}};
         spare_vld_r <= 1'b0;
      end else begin
         // head slot drives the output, spare slot absorbs a stall
         if (pop || !out_valid) begin
            if (spare_vld_r) begin
               out_data <= spare_r;
               out_valid <= 1'b1;
               spare_vld_r <= push;
               if (push) spare_r <= in_data;
            end else begin
               out_valid <= push;
               if (push) out_data <= in_data;
            end
         end else if (push) begin
            spare_r <= in_data;
            spare_vld_r <= 1'b1;
         end
         // full next cycle when both slots hold a word, including a pop plus push with spare held
         in_ready <= (out_valid && !pop) ? !(spare_vld_r || push) : !(spare_vld_r && push);
      end
   end
endmodule // bmce_buf2
`default_nettype wire

// >>> core/bmce_exec.v
// execution unit for stack-top swap and block copy/compare instructions
//
// Contract
// - DD E3 swaps first base low with (stack top), high with (stack top+1).
// - FD E3 does the same swap using the second base.
// - swap takes six machine cycles 4,4,3,4,3,5 states; flags unchanged.
// - copy up moves (source) to (target), bumps both, counter minus one; 4,4,3,5.
// - repeating copy up reruns via program counter minus 2 until counter zero.
// - repeating iteration takes 4,4,3,5,5; the final one 4,4,3,5.
// - repeats accept interrupts between iterations; two refreshes per byte moved.
// - counter zero at start wraps, so 64K bytes move.
// - copy down moves one byte then decrements source, target and counter.
// - repeating copy down repeats like the upward form until counter zero.
// - repeat completion clears half-carry, parity/overflow, subtract; keeps S, Z, C.
// - compare up subtracts (source) from accumulator, flags equality, bumps the source pointer but not the target, counter minus one.
// - compare flags: S result, Z equal, H bit-4 borrow, PV counter nonzero, N set.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "bmce_regs.vh"
module bmce_exec #(
   parameter AW = 16
) (
   input wire clk,
   input wire arst_n,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg [AW-1:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg mem_rd,
   output reg mem_wr,
   output reg mem_rfsh,
   input wire [7:0] mem_rdata,
   input wire mem_rdata_valid,
   output wire mem_rdata_ready,
   input wire int_req,
   output reg int_ack,
   output reg busy
);
   // ==========================================
   // instruction kinds
   localparam K_SWAP1 = 3'd0;
   localparam K_SWAP2 = 3'd1;
   localparam K_CPY_UP = 3'd2;
   localparam K_RPT_UP = 3'd3;
   localparam K_CPY_DN = 3'd4;
   localparam K_RPT_DN = 3'd5;
   localparam K_CMP_UP = 3'd6;

   reg [7:0] acc_r;
   reg [7:0] flags_r;
   reg [15:0] byte_ctr_r;
   reg [15:0] target_r;
   reg [15:0] source_r;
   reg [15:0] stack_top_r;
   reg [15:0] first_base_r;
   reg [15:0] second_base_r;
   reg [15:0] pc_r;
   reg [2:0] kind_r;
   reg [2:0] m_r;
   reg [2:0] t_r;
   reg [7:0] tmp_lo_r;
   reg [7:0] tmp_hi_r;
   reg bad_op_r;
   reg int_taken_r;

   // ==========================================
   // read-data buffer
   wire byte_vld;
   wire [7:0] byte_in;
   wire is_swap = (kind_r == K_SWAP1) || (kind_r == K_SWAP2);
   wire is_rpt = (kind_r == K_RPT_UP) || (kind_r == K_RPT_DN);
   wire is_down = (kind_r == K_CPY_DN) || (kind_r == K_RPT_DN);
   wire rd_cycle = (m_r == 3'd2) || (is_swap && m_r == 3'd3);
   reg [2:0] m_len;
   wire last_t = (t_r == m_len);
   // memory late with data stretches the read cycle instead of losing it
   wire stall = rd_cycle && !byte_vld;
   wire take_byte = busy && last_t && rd_cycle && byte_vld;

   bmce_buf2 #(.W(8)) u_buf (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(mem_rdata_valid),
      .in_ready(mem_rdata_ready),
      .in_data(mem_rdata),
      .out_valid(byte_vld),
      .out_ready(take_byte),
      .out_data(byte_in)
   );

   // ==========================================
   // machine-cycle lengths
   always @* begin
      case (m_r)
         3'd0: m_len = `BMCE_T4;
         3'd1: m_len = `BMCE_T4;
         3'd2: m_len = `BMCE_T3;
         3'd3: m_len = is_swap ? `BMCE_T4 : `BMCE_T5;
         3'd4: m_len = is_swap ? `BMCE_T3 : `BMCE_T5;
         3'd5: m_len = `BMCE_T5;
         default: m_len = `BMCE_T3;
      endcase
   end

   // ==========================================
   // datapath values
   wire [15:0] base_sel = (kind_r == K_SWAP2) ? second_base_r : first_base_r;
   wire [15:0] stack_nx = stack_top_r + 16'h0001;
   // counter zero wraps to all ones, giving a 64K-byte run
   wire [15:0] ctr_dec = byte_ctr_r - 16'h0001;
   wire ctr_nz = (ctr_dec != 16'h0000);
   wire [15:0] ptr_step = is_down ? 16'hFFFF : 16'h0001;
   wire [8:0] diff = {1'b0, acc_r} - {1'b0, tmp_lo_r};
   wire half_borrow = (acc_r[3:0] < tmp_lo_r[3:0]);

   // decode of the command word
   reg [2:0] dec_kind;
   reg dec_ok;
   always @* begin
      dec_ok = 1'b1;
      dec_kind = K_SWAP1;
      case (reg_wdata)
         {`BMCE_PFX_FIRST, `BMCE_OP_SWAP_STACK}: dec_kind = K_SWAP1;
         {`BMCE_PFX_SECOND, `BMCE_OP_SWAP_STACK}: dec_kind = K_SWAP2;
         {`BMCE_PFX_BLOCK, `BMCE_OP_COPY_UP}: dec_kind = K_CPY_UP;
         {`BMCE_PFX_BLOCK, `BMCE_OP_COPY_REP_UP}: dec_kind = K_RPT_UP;
         {`BMCE_PFX_BLOCK, `BMCE_OP_COPY_DOWN}: dec_kind = K_CPY_DN;
         {`BMCE_PFX_BLOCK, `BMCE_OP_COPY_REP_DOWN}: dec_kind = K_RPT_DN;
         {`BMCE_PFX_BLOCK, `BMCE_OP_CMP_UP}: dec_kind = K_CMP_UP;
         default: dec_ok = 1'b0;
      endcase
   end

   // bus request for the machine cycle about to begin (index m_r + 1)
   reg nx_rd;
   reg nx_wr;
   reg [15:0] nx_addr;
   reg [7:0] nx_wdata;
   always @* begin
      nx_rd = 1'b0;
      nx_wr = 1'b0;
      nx_addr = pc_r;
      nx_wdata = `BMCE_RST_BYTE;
      case (m_r)
         3'd1: begin
            nx_rd = 1'b1;
            nx_addr = is_swap ? stack_top_r : source_r;
         end
         3'd2: begin
            if (is_swap) begin
               nx_rd = 1'b1;
               nx_addr = stack_nx;
            end else if (kind_r != K_CMP_UP) begin
               nx_wr = 1'b1;
               nx_addr = target_r;
               nx_wdata = byte_in;
            end
         end
         3'd3: begin
            if (is_swap) begin
               nx_wr = 1'b1;
               nx_addr = stack_nx;
               nx_wdata = base_sel[15:8];
            end
         end
         3'd4: begin
            if (is_swap) begin
               nx_wr = 1'b1;
               nx_addr = stack_top_r;
               nx_wdata = base_sel[7:0];
            end
         end
         default: begin
            nx_rd = 1'b0;
         end
      endcase
   end

   // ==========================================
   // sequencer and register file
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= `BMCE_RST_BYTE;
         flags_r <= `BMCE_RST_BYTE;
         byte_ctr_r <= `BMCE_RST_WORD;
         target_r <= `BMCE_RST_WORD;
         source_r <= `BMCE_RST_WORD;
         stack_top_r <= `BMCE_RST_WORD;
         first_base_r <= `BMCE_RST_WORD;
         second_base_r <= `BMCE_RST_WORD;
         pc_r <= `BMCE_RST_WORD;
         kind_r <= K_SWAP1;
         m_r <= 3'd0;
         t_r <= 3'd1;
         tmp_lo_r <= `BMCE_RST_BYTE;
         tmp_hi_r <= `BMCE_RST_BYTE;
         bad_op_r <= 1'b0;
         int_taken_r <= 1'b0;
         reg_rdata <= `BMCE_RST_WORD;
         mem_addr <= {AW{1'b0}};
         mem_wdata <= `BMCE_RST_BYTE;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_rfsh <= 1'b0;
         int_ack <= 1'b0;
         busy <= 1'b0;
      end else begin
         mem_rfsh <= 1'b0;
         int_ack <= 1'b0;
         if (reg_rd) begin
            case (reg_addr)
               `BMCE_IDX_ACC: reg_rdata <= {8'h00, acc_r};
               `BMCE_IDX_FLAGS: reg_rdata <= {8'h00, flags_r};
               `BMCE_IDX_BYTE_CTR: reg_rdata <= byte_ctr_r;
               `BMCE_IDX_TARGET: reg_rdata <= target_r;
               `BMCE_IDX_SOURCE: reg_rdata <= source_r;
               `BMCE_IDX_STACK_TOP: reg_rdata <= stack_top_r;
               `BMCE_IDX_FIRST_BASE: reg_rdata <= first_base_r;
               `BMCE_IDX_SECOND_BASE: reg_rdata <= second_base_r;
               `BMCE_IDX_PC: reg_rdata <= pc_r;
               `BMCE_IDX_STATUS: reg_rdata <= {13'h0000, int_taken_r, bad_op_r, busy};
               default: reg_rdata <= `BMCE_RST_WORD;
            endcase
         end
         // register writes are ignored while an instruction runs
         if (reg_wr && !busy) begin
            case (reg_addr)
               `BMCE_IDX_ACC: acc_r <= reg_wdata[7:0];
               `BMCE_IDX_FLAGS: flags_r <= reg_wdata[7:0];
               `BMCE_IDX_BYTE_CTR: byte_ctr_r <= reg_wdata;
               `BMCE_IDX_TARGET: target_r <= reg_wdata;
               `BMCE_IDX_SOURCE: source_r <= reg_wdata;
               `BMCE_IDX_STACK_TOP: stack_top_r <= reg_wdata;
               `BMCE_IDX_FIRST_BASE: first_base_r <= reg_wdata;
               `BMCE_IDX_SECOND_BASE: second_base_r <= reg_wdata;
               `BMCE_IDX_PC: pc_r <= reg_wdata;
               `BMCE_IDX_CMD: begin
                  bad_op_r <= !dec_ok;
                  int_taken_r <= 1'b0;
                  if (dec_ok) begin
                     kind_r <= dec_kind;
                     busy <= 1'b1;
                     m_r <= 3'd0;
                     t_r <= 3'd1;
                     mem_addr <= pc_r[AW-1:0];
                  end
               end
               default: begin
                  bad_op_r <= bad_op_r;
               end
            endcase
         end
         if (busy) begin
            if (!last_t) begin
               t_r <= t_r + 3'd1;
            end else if (!stall) begin
               t_r <= 3'd1;
               m_r <= m_r + 3'd1;
               mem_rd <= nx_rd;
               mem_wr <= nx_wr;
               mem_addr <= nx_addr[AW-1:0];
               mem_wdata <= nx_wdata;
               case (m_r)
                  3'd0, 3'd1: begin
                     // each opcode fetch ends with a refresh slot
                     pc_r <= pc_r + 16'h0001;
                     mem_rfsh <= 1'b1;
                  end
                  3'd2: begin
                     tmp_lo_r <= byte_in;
                  end
                  3'd3: begin
                     if (is_swap) begin
                        tmp_hi_r <= byte_in;
                     end else begin
                        source_r <= source_r + ptr_step;
                        byte_ctr_r <= ctr_dec;
                        if (kind_r == K_CMP_UP) begin
                           flags_r[`BMCE_FLAG_S] <= diff[7];
                           flags_r[`BMCE_FLAG_Z] <= (diff[7:0] == 8'h00);
                           flags_r[`BMCE_FLAG_H] <= half_borrow;
                           flags_r[`BMCE_FLAG_PV] <= ctr_nz;
                           flags_r[`BMCE_FLAG_N] <= 1'b1;
                        end else begin
                           target_r <= target_r + ptr_step;
                           flags_r[`BMCE_FLAG_H] <= 1'b0;
                           flags_r[`BMCE_FLAG_N] <= 1'b0;
                           // a finished repeat has a zero counter, so PV clears
                           flags_r[`BMCE_FLAG_PV] <= ctr_nz;
                        end
                        if (!(is_rpt && ctr_nz)) begin
                           busy <= 1'b0;
                           mem_rd <= 1'b0;
                           mem_wr <= 1'b0;
                        end
                     end
                  end
                  3'd4: begin
                     if (!is_swap) begin
                        pc_r <= pc_r - 16'h0002;
                        mem_rd <= 1'b0;
                        mem_wr <= 1'b0;
                        m_r <= 3'd0;
                        mem_addr <= pc_r[AW-1:0] - {{(AW-2){1'b0}}, 2'b10};
                        // pending interrupt is served between iterations
                        if (int_req) begin
                           int_ack <= 1'b1;
                           int_taken_r <= 1'b1;
                           busy <= 1'b0;
                        end
                     end
                  end
                  3'd5: begin
                     // flags untouched by the swap
                     if (kind_r == K_SWAP2) begin
                        second_base_r <= {tmp_hi_r, tmp_lo_r};
                     end else begin
                        first_base_r <= {tmp_hi_r, tmp_lo_r};
                     end
                     busy <= 1'b0;
                     mem_rd <= 1'b0;
                     mem_wr <= 1'b0;
                     m_r <= 3'd0;
                  end
                  default: begin
                     busy <= 1'b0;
                  end
               endcase
            end
         end
      end
   end
endmodule // bmce_exec
`default_nettype wire

// >>> tb/bmce_exec_properties.sv
// assertion checker for the execution unit's register and memory ports
`timescale 1ns/1ns
`default_nettype none
`include "bmce_regs.vh"
module bmce_exec_properties #(
   parameter AW = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic mem_rfsh,
   input wire logic int_req,
   input wire logic int_ack,
   input wire logic busy
);
   // ==========
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire [7:0] pfx = reg_wdata[15:8];
   wire [7:0] op = reg_wdata[7:0];
   wire known = (pfx == 8'hED && (op == 8'hA0 || op == 8'hB0 || op == 8'hA8 || op == 8'hB8
      || op == 8'hA1)) || ((pfx == 8'hDD || pfx == 8'hFD) && op == 8'hE3);
   wire start = reg_wr && reg_addr == `BMCE_IDX_CMD && !busy;
   sequence s_go;
      start && known;
   endsequence
   sequence s_stand;
      ($stable(mem_addr) && $stable(mem_wdata))[*2];
   endsequence
   property p_go; s_go |=> busy; endproperty
   property p_refuse; start && !known |=> !busy; endproperty
   property p_excl; !(mem_rd && mem_wr); endproperty
   property p_rd_len; $rose(mem_rd) |-> mem_rd[*3]; endproperty
   property p_wr_len; $rose(mem_wr) |-> mem_wr[*3]; endproperty
   property p_wr_stand; $rose(mem_wr) |=> s_stand; endproperty
   property p_idle; !busy |-> !mem_rd && !mem_wr; endproperty
   property p_rfsh; mem_rfsh |=> !mem_rfsh; endproperty
   property p_ack; int_ack |-> $past(int_req) && !busy; endproperty
   property p_unmapped; reg_rd && reg_addr > 4'hA |=> reg_rdata == 16'h0000; endproperty
   a_go: assert property (p_go) else $error("command not started");
   a_refuse: assert property (p_refuse) else $error("unknown code started");
   a_excl: assert property (p_excl) else $error("read and write together");
   a_rd_len: assert property (p_rd_len) else $error("read cycle too short");
   a_wr_len: assert property (p_wr_len) else $error("write cycle too short");
   a_wr_stand: assert property (p_wr_stand) else $error("write moved");
   a_idle: assert property (p_idle) else $error("memory access when idle");
   a_rfsh: assert property (p_rfsh) else $error("refresh too long");
   a_ack: assert property (p_ack) else $error("stray interrupt stop");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule // bmce_exec_properties
`default_nettype wire

// >>> tb/bmce_mem_model.sv
// byte-wide memory model answering the execution unit's machine cycles
`timescale 1ns/1ns
`default_nettype none
module bmce_mem_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic slow,
   output logic [7:0] mem_rdata,
   output logic mem_rdata_valid,
   input wire logic mem_rdata_ready
);
   // ==========
   // storage
   logic [7:0] mem [0:65535];
   logic rd_q;
   logic [15:0] addr_q;
   logic [2:0] wait_c;
   // back-to-back reads keep the strobe high, so a new address is a new cycle
   wire new_rd = mem_rd && (!rd_q || mem_addr != addr_q);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_q <= 1'b0;
         addr_q <= 16'h0000;
         wait_c <= 3'd0;
         mem_rdata_valid <= 1'b0;
         mem_rdata <= 8'h5a;
      end else begin
         rd_q <= mem_rd;
         addr_q <= mem_addr;
         if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
         end
         if (new_rd && slow) begin
            wait_c <= 3'd4;
         end else if (wait_c != 3'd0) begin
            wait_c <= wait_c - 3'd1;
         end
         if (mem_rdata_valid) begin
            if (mem_rdata_ready) begin
               mem_rdata_valid <= 1'b0;
               mem_rdata <= ~mem_rdata;
            end
         end else if ((new_rd && !slow) || wait_c == 3'd1) begin
            mem_rdata_valid <= 1'b1;
            mem_rdata <= mem[mem_addr];
         end else begin
            // released line toggles so no stale byte looks good
            mem_rdata <= ~mem_rdata;
         end
      end
   end
endmodule // bmce_mem_model
`default_nettype wire

// >>> tb/block_move_compare_exec_tb.sv
// self-checking bench for the stack swap and block copy/compare unit
`timescale 1ns/1ns
`default_nettype none
`include "bmce_regs.vh"
module block_move_compare_exec_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic int_req = 1'b0;
   logic slow = 1'b0;
   wire logic [15:0] reg_rdata, mem_addr;
   wire logic [7:0] mem_wdata, mem_rdata;
   wire logic mem_rd, mem_wr, mem_rfsh, mem_rdata_valid, mem_rdata_ready, int_ack, busy;
   int n_errors = 0;
   int checked = 0;
   int cyc, rf, ack;
   always #20 clk = ~clk;
   bmce_exec #(.AW(16)) i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_rfsh(mem_rfsh), .mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid),
      .mem_rdata_ready(mem_rdata_ready), .int_req(int_req), .int_ack(int_ack), .busy(busy));
   bmce_mem_model i_mem (.clk(clk), .arst_n(arst_n), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .slow(slow),
      .mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid),
      .mem_rdata_ready(mem_rdata_ready));
   // ==========
   // bus tasks
   task automatic conclude;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask
   // counts busy cycles and refresh pulses, bounded so a hang ends the run
   task automatic run(input logic [15:0] cmd);
      wr(`BMCE_IDX_CMD, cmd);
      cyc = 0;
      rf = 0;
      @(negedge clk);
      while (busy === 1'b1) begin
         cyc++;
         rf += int'(mem_rfsh);
         if (cyc > 4000) begin
            n_errors++;
            conclude();
         end
         @(negedge clk);
      end
      ack = int'(int_ack);
   endtask
   // ==========
   // scenarios
   task automatic t_swap(input logic [7:0] pfx, input logic [3:0] ix);
      wr(`BMCE_IDX_STACK_TOP, 16'h0100);
      wr(ix, 16'h3988);
      wr(`BMCE_IDX_FLAGS, 16'h00d5);
      i_mem.mem[16'h0100] = 8'h90;
      i_mem.mem[16'h0101] = 8'h48;
      run({pfx, 8'he3});
      chk(16'(cyc), 16'h0017);
      rd(ix, 16'h4890);
      rd(`BMCE_IDX_FLAGS, 16'h00d5);
      rd(`BMCE_IDX_STACK_TOP, 16'h0100);
      chk({i_mem.mem[16'h0101], i_mem.mem[16'h0100]}, 16'h3988);
   endtask
   task automatic t_copy(input logic [7:0] op, input logic [15:0] hl, input logic [15:0] de,
         input logic [15:0] bc, input int n, input logic [7:0] f0);
      logic [15:0] s;
      logic [7:0] fx;
      logic [7:0] ex;
      for (int k = 0; k < 8; k++) begin
         i_mem.mem[16'h1110 + k] = 8'ha0 + 8'(k);
         i_mem.mem[16'h2220 + k] = 8'h66;
      end
      wr(`BMCE_IDX_SOURCE, hl);
      wr(`BMCE_IDX_TARGET, de);
      wr(`BMCE_IDX_BYTE_CTR, bc);
      wr(`BMCE_IDX_FLAGS, {8'h00, f0});
      run({8'hed, op});
      if (!slow) chk(16'(cyc), op[4] ? 16'(21 * n - 5) : 16'h0010);
      chk(16'(rf), 16'(2 * n));
      s = op[3] ? -16'(n) : 16'(n);
      rd(`BMCE_IDX_SOURCE, hl + s);
      rd(`BMCE_IDX_TARGET, de + s);
      rd(`BMCE_IDX_BYTE_CTR, bc - 16'(n));
      // half-carry and subtract clear, parity/overflow only while the counter is left nonzero
      fx = (f0 & 8'he9) | ((bc != 16'(n)) ? 8'h04 : 8'h00);
      rd(`BMCE_IDX_FLAGS, {8'h00, fx});
      for (int k = 0; k <= n; k++) begin
         s = op[3] ? -16'(k) : 16'(k);
         ex = (k < n) ? i_mem.mem[hl + s] : 8'h66;
         chk({8'h00, i_mem.mem[de + s]}, {8'h00, ex});
      end
   endtask
   task automatic t_cmp(input logic [7:0] a, input logic [7:0] m, input logic [15:0] bc,
         input logic [7:0] f0, input logic [7:0] f1);
      i_mem.mem[16'h1111] = m;
      wr(`BMCE_IDX_ACC, {8'h00, a});
      wr(`BMCE_IDX_SOURCE, 16'h1111);
      wr(`BMCE_IDX_BYTE_CTR, bc);
      wr(`BMCE_IDX_FLAGS, {8'h00, f0});
      run(16'heda1);
      chk(16'(cyc), 16'h0010);
      rd(`BMCE_IDX_FLAGS, {8'h00, f1});
      rd(`BMCE_IDX_ACC, {8'h00, a});
      rd(`BMCE_IDX_SOURCE, 16'h1112);
      rd(`BMCE_IDX_BYTE_CTR, bc - 16'h0001);
      chk({8'h00, i_mem.mem[16'h1111]}, {8'h00, m});
   endtask
   task automatic t_intr;
      wr(`BMCE_IDX_PC, 16'h0040);
      wr(`BMCE_IDX_BYTE_CTR, 16'h0000);
      wr(`BMCE_IDX_SOURCE, 16'h1111);
      wr(`BMCE_IDX_TARGET, 16'h2222);
      int_req <= 1'b1;
      run(16'hedb0);
      @(posedge clk);
      int_req <= 1'b0;
      chk(16'(cyc), 16'h0015);
      chk(16'(ack), 16'h0001);
      rd(`BMCE_IDX_BYTE_CTR, 16'hffff);
      rd(`BMCE_IDX_PC, 16'h0040);
      rd(`BMCE_IDX_STATUS, 16'h0004);
      chk({8'h00, i_mem.mem[16'h2222]}, {8'h00, i_mem.mem[16'h1111]});
   endtask
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'hf, 16'h0000);
      chk({15'h0000, mem_rdata_ready}, 16'h0001);
      run(16'hedb1);
      chk(16'(cyc), 16'h0000);
      rd(`BMCE_IDX_STATUS, 16'h0002);
      t_swap(8'hdd, `BMCE_IDX_FIRST_BASE);
      t_swap(8'hfd, `BMCE_IDX_SECOND_BASE);
      t_copy(8'ha0, 16'h1111, 16'h2222, 16'h0007, 1, 8'hff);
      t_copy(8'ha8, 16'h1111, 16'h2222, 16'h0001, 1, 8'h16);
      t_copy(8'hb0, 16'h1111, 16'h2222, 16'h0003, 3, 8'hff);
      @(posedge clk);
      slow <= 1'b1;
      t_copy(8'hb8, 16'h1114, 16'h2225, 16'h0003, 3, 8'h00);
      @(posedge clk);
      slow <= 1'b0;
      t_cmp(8'h3b, 8'h3b, 16'h0001, 8'h01, 8'h43);
      t_cmp(8'h00, 8'h01, 16'h0002, 8'h00, 8'h96);
      t_intr();
      conclude();
   end
endmodule // block_move_compare_exec_tb
bind bmce_exec bmce_exec_properties #(.AW(AW)) i_props (.clk(clk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .mem_rfsh(mem_rfsh), .int_req(int_req), .int_ack(int_ack), .busy(busy));
`default_nettype wire
